// ### inc/essl_consts.svh
// register indices, component numbers, field positions and save-area layout
`ifndef ESSL_CONSTS_SVH
`define ESSL_CONSTS_SVH

// register word indices (byte address = 4 * index)
`define ESSL_R_CTRL    4'h0
`define ESSL_R_UCE     4'h1
`define ESSL_R_SCE     4'h2
`define ESSL_R_BASE    4'h3
`define ESSL_R_REQ     4'h4
`define ESSL_R_CMD     4'h5
`define ESSL_R_STAT    4'h6
`define ESSL_R_PK      4'h7
`define ESSL_R_TLO     4'h8
`define ESSL_R_THI     4'h9

// state component numbers
`define ESSL_C_BND     4'h3
`define ESSL_C_CSR     4'h4
`define ESSL_C_MASK    4'h5
`define ESSL_C_UPPER   4'h6
`define ESSL_C_HIGH    4'h7
`define ESSL_C_TRACE   4'h8
`define ESSL_C_PK      4'h9
`define ESSL_C_LAST    4'h9

// field positions
`define ESSL_CTRL_OSEN 0
`define ESSL_CTRL_M64  1
`define ESSL_TRACE_EN  0
`define ESSL_BND_LO    3
`define ESSL_BND_HI    4
`define ESSL_WIDE_LO   5
`define ESSL_WIDE_HI   7
`define ESSL_TRACE_BIT 8
`define ESSL_PK_BIT    9

// section start, in 8-byte words from the area base
`define ESSL_O_BND     8'h00
`define ESSL_O_CSR     8'h08
`define ESSL_O_MASK    8'h0A
`define ESSL_O_UPPER   8'h12
`define ESSL_O_HIGH    8'h52
`define ESSL_O_TRACE   8'hD2
`define ESSL_O_PK      8'hDD

// section lengths in 8-byte words
`define ESSL_N_BND     8'h08
`define ESSL_N_CSR     8'h02
`define ESSL_N_MASK    8'h08
`define ESSL_N_UPPER   8'h40
`define ESSL_N_UPPER32 8'h20
`define ESSL_N_HIGH    8'h80
`define ESSL_N_TRACE   8'h09
`define ESSL_N_TRSV    8'h0B
`define ESSL_N_PK      8'h01

`define ESSL_PK_BE     8'h0F
`define ESSL_ALL_BE    8'hFF
`define ESSL_SUP_MASK  10'h100
`define ESSL_RST_32    32'h0000_0000
`define ESSL_RST_64    64'h0000_0000_0000_0000

`endif

// ### inc/essl_pkg.sv
// types shared by the save/restore sequencer
package essl_pkg;
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_NEXT, S_REQ, S_STORE, S_FINISH, S_ABORT} essl_state_t;
  typedef enum logic [1:0] {OP_SAVE, OP_SSAVE, OP_REST, OP_SREST} essl_op_t;
  typedef enum logic [1:0] {F_NONE, F_GP, F_MEM, F_VMX} essl_fault_t;
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [7:0]  be;
  } essl_mem_t;
  typedef struct packed {
    logic [3:0]  comp;
    logic [7:0]  idx;
    logic [63:0] wdata;
  } essl_st_t;
endpackage

// ### hdl/essl_gate.sv
// enable gate for one group of state components
`timescale 1ns/100ps
module essl_gate #(
  parameter int LO = 0,
  parameter int HI = 0
) (
  // configuration
  input  wire logic        os_en_i,
  input  wire logic [31:0] mask_i,
  // result
  output logic             en_o
);
  // every bit of the group must be set, a partial group manages nothing
  assign en_o = os_en_i && (&mask_i[HI:LO]);
endmodule

// ### hdl/essl_core.sv
// save/restore sequencer for bounds, wide-vector, trace and protection-key state
// Function
// - components: bounds 3-4, vector 5-7, trace 8, keys 9
// - bound register i at bytes 16i+15:16i
// - user config bytes 7:0, status bytes 15:8
// - bounds need os enable and bits 4:3 set
// - refuse bounds instructions unless bounds enabled
// - mask register i at bytes 8i+7:8i
// - upper halves at bytes 32i+31:32i
// - outside 64-bit mode skip halves 8-15
// - high vector i at 64(i-16)
// - outside 64-bit mode skip high bank
// - vector needs bits 7:5; else refuse instructions
// - nine trace registers in 8-byte slots
// - trace bytes 72 and above are reserved
// - supervisor save writes zero to reserved
// - trace needs os enable and supervisor bit 8
// - clear trace enable after saving control word
// - fault during save restores trace enable
// - restore with trace enabled gives protection fault
// - restore faults precede trace enable change
// - key rights register in bytes 3:0
// - keys need os enable and bit 9
// - restore checks rights held before operation
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "essl_consts.svh"
module essl_core (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // avalon-mm register slave
  input  wire logic [3:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // save area memory
  output logic                    mem_valid_o,
  output essl_pkg::essl_mem_t     mem_req_o,
  input  wire logic               mem_ack_i,
  input  wire logic               mem_err_i,
  input  wire logic [63:0]        mem_rdata_i,
  input  wire logic               vm_exit_i,
  // external state registers
  output logic                    st_we_o,
  output essl_pkg::essl_st_t      st_o,
  input  wire logic [63:0]        st_rdata_i,
  // pipeline side
  input  wire logic               bounds_insn_i,
  input  wire logic               wide_insn_i,
  output logic                    bounds_refuse_o,
  output logic                    wide_refuse_o,
  output logic [31:0]             rights_o,
  output logic                    busy_o
);
  logic                   os_en_r;
  logic                   mode64_r;
  logic [31:0]            uce_r;
  logic [31:0]            sce_r;
  logic [31:0]            base_r;
  logic [9:0]             reqmask_r;
  logic [31:0]            protection_key_rights_reg_r;
  logic [31:0]            protection_key_rights_reg_pend_r;
  logic                   protection_key_rights_reg_pend_v;
  logic [31:0]            protection_key_rights_reg_snap_r;
  logic [63:0]            tctl_r;
  logic [63:0]            tctl_pend_r;
  logic                   tctl_pend_v;
  logic                   saved_en_r;
  logic                   trace_clr_r;
  essl_pkg::essl_state_t  st_r;
  essl_pkg::essl_op_t     op_r;
  essl_pkg::essl_fault_t  fault_r;
  logic                   done_r;
  logic [3:0]             comp_r;
  logic [7:0]             idx_r;
  logic [63:0]            rdata_r;
  essl_pkg::essl_mem_t    mreq_r;
  logic                   rsp_r;
  logic [31:0]            rd_nxt;
  logic                   en_bnd;
  logic                   en_wide;
  logic                   en_tr;
  logic                   en_pk;
  logic [9:0]             comp_en;
  logic [9:0]             rfbm;
  logic                   is_save;
  logic                   is_sup;
  logic                   wr_acc;
  logic                   cmd_go;
  logic                   idle;
  logic [7:0]             cnt;
  logic [7:0]             sec;
  logic [7:0]             word;
  logic                   ext;

  essl_gate #(.LO(`ESSL_BND_LO), .HI(`ESSL_BND_HI)) u_bnd (
    .os_en_i (os_en_r),
    .mask_i  (uce_r),
    .en_o    (en_bnd)
  );
  essl_gate #(.LO(`ESSL_WIDE_LO), .HI(`ESSL_WIDE_HI)) u_wide (
    .os_en_i (os_en_r),
    .mask_i  (uce_r),
    .en_o    (en_wide)
  );
  essl_gate #(.LO(`ESSL_TRACE_BIT), .HI(`ESSL_TRACE_BIT)) u_tr (
    .os_en_i (os_en_r),
    .mask_i  (sce_r),
    .en_o    (en_tr)
  );
  essl_gate #(.LO(`ESSL_PK_BIT), .HI(`ESSL_PK_BIT)) u_pk (
    .os_en_i (os_en_r),
    .mask_i  (uce_r),
    .en_o    (en_pk)
  );

  assign comp_en = {en_pk, en_tr, {3{en_wide}}, {2{en_bnd}}, 3'h0};
  assign is_save = (op_r == essl_pkg::OP_SAVE) || (op_r == essl_pkg::OP_SSAVE);
  assign is_sup  = (op_r == essl_pkg::OP_SSAVE) || (op_r == essl_pkg::OP_SREST);
  // user operations never reach the supervisor trace group
  assign rfbm    = reqmask_r & comp_en & (is_sup ? 10'h3FF : ~`ESSL_SUP_MASK);
  assign idle    = (st_r == essl_pkg::S_IDLE);
  assign busy_o  = !idle;
  assign bounds_refuse_o = bounds_insn_i && !en_bnd;
  assign wide_refuse_o   = wide_insn_i && !en_wide;
  assign rights_o = idle ? protection_key_rights_reg_r : protection_key_rights_reg_snap_r;

  // section length and start for the component under walk
  always_comb begin
    cnt = 8'h00;
    sec = 8'h00;
    case (comp_r)
      `ESSL_C_BND: begin
        cnt = `ESSL_N_BND;
        sec = `ESSL_O_BND;
      end
      `ESSL_C_CSR: begin
        cnt = `ESSL_N_CSR;
        sec = `ESSL_O_CSR;
      end
      `ESSL_C_MASK: begin
        cnt = `ESSL_N_MASK;
        sec = `ESSL_O_MASK;
      end
      `ESSL_C_UPPER: begin
        cnt = mode64_r ? `ESSL_N_UPPER : `ESSL_N_UPPER32;
        sec = `ESSL_O_UPPER;
      end
      `ESSL_C_HIGH: begin
        cnt = mode64_r ? `ESSL_N_HIGH : 8'h00;
        sec = `ESSL_O_HIGH;
      end
      `ESSL_C_TRACE: begin
        cnt = is_save ? `ESSL_N_TRSV : `ESSL_N_TRACE;
        sec = `ESSL_O_TRACE;
      end
      `ESSL_C_PK: begin
        cnt = `ESSL_N_PK;
        sec = `ESSL_O_PK;
      end
      default: begin
        cnt = 8'h00;
        sec = 8'h00;
      end
    endcase
  end

  assign word = 8'(sec + idx_r);
  // trace control and key rights live here, everything else outside
  assign ext  = !((comp_r == `ESSL_C_TRACE) && (idx_r == 8'h00)) && (comp_r != `ESSL_C_PK);

  // avalon slave: one wait state on every access
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !rsp_r;
  assign wr_acc = avs_write_i && rsp_r;
  assign cmd_go = wr_acc && (avs_address_i == `ESSL_R_CMD) && idle;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rsp_r <= 1'b0;
    end else begin
      rsp_r <= (avs_read_i || avs_write_i) && !rsp_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address_i)
      `ESSL_R_CTRL: rd_nxt = {30'h0, mode64_r, os_en_r};
      `ESSL_R_UCE:  rd_nxt = uce_r;
      `ESSL_R_SCE:  rd_nxt = sce_r;
      `ESSL_R_BASE: rd_nxt = base_r;
      `ESSL_R_REQ:  rd_nxt = {22'h0, reqmask_r};
      `ESSL_R_STAT: rd_nxt = {28'h0, fault_r, done_r, busy_o};
      `ESSL_R_PK:   rd_nxt = protection_key_rights_reg_r;
      `ESSL_R_TLO:  rd_nxt = tctl_r[31:0];
      `ESSL_R_THI:  rd_nxt = tctl_r[63:32];
      default:      rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_readdata_o <= `ESSL_RST_32;
    end else if (avs_read_i && !rsp_r) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // configuration is frozen while an operation walks the area
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      os_en_r   <= 1'b0;
      mode64_r  <= 1'b0;
      uce_r     <= `ESSL_RST_32;
      sce_r     <= `ESSL_RST_32;
      base_r    <= `ESSL_RST_32;
      reqmask_r <= 10'h000;
    end else if (wr_acc && idle) begin
      case (avs_address_i)
        `ESSL_R_CTRL: begin
          os_en_r  <= avs_writedata_i[`ESSL_CTRL_OSEN];
          mode64_r <= avs_writedata_i[`ESSL_CTRL_M64];
        end
        `ESSL_R_UCE:  uce_r <= avs_writedata_i;
        `ESSL_R_SCE:  sce_r <= avs_writedata_i;
        `ESSL_R_BASE: base_r <= avs_writedata_i;
        `ESSL_R_REQ:  reqmask_r <= avs_writedata_i[9:0];
        default: ;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r    <= essl_pkg::S_IDLE;
      op_r    <= essl_pkg::OP_SAVE;
      fault_r <= essl_pkg::F_NONE;
      done_r  <= 1'b0;
      comp_r  <= `ESSL_C_BND;
      idx_r   <= 8'h00;
      rdata_r <= `ESSL_RST_64;
    end else begin
      unique case (st_r)
        essl_pkg::S_IDLE: if (cmd_go) begin
          op_r    <= essl_pkg::essl_op_t'(avs_writedata_i[1:0]);
          fault_r <= essl_pkg::F_NONE;
          done_r  <= 1'b0;
          comp_r  <= `ESSL_C_BND;
          idx_r   <= 8'h00;
          st_r    <= essl_pkg::S_CHECK;
        end
        essl_pkg::S_CHECK: begin
          if (op_r == essl_pkg::OP_SREST && rfbm[`ESSL_TRACE_BIT] && tctl_r[`ESSL_TRACE_EN]) begin
            fault_r <= essl_pkg::F_GP;
            st_r    <= essl_pkg::S_ABORT;
          end else begin
            st_r <= essl_pkg::S_NEXT;
          end
        end
        essl_pkg::S_NEXT: begin
          if (comp_r > `ESSL_C_LAST) begin
            st_r <= essl_pkg::S_FINISH;
          end else if (rfbm[comp_r] && idx_r < cnt) begin
            st_r <= essl_pkg::S_REQ;
          end else begin
            comp_r <= comp_r + 4'h1;
            idx_r  <= 8'h00;
          end
        end
        essl_pkg::S_REQ: begin
          if (vm_exit_i) begin
            fault_r <= essl_pkg::F_VMX;
            st_r    <= essl_pkg::S_ABORT;
          end else if (mem_ack_i && mem_err_i) begin
            fault_r <= essl_pkg::F_MEM;
            st_r    <= essl_pkg::S_ABORT;
          end else if (mem_ack_i) begin
            rdata_r <= mem_rdata_i;
            st_r    <= essl_pkg::S_STORE;
          end
        end
        essl_pkg::S_STORE: begin
          idx_r <= idx_r + 8'h01;
          st_r  <= essl_pkg::S_NEXT;
        end
        essl_pkg::S_FINISH, essl_pkg::S_ABORT: begin
          done_r <= 1'b1;
          st_r   <= essl_pkg::S_IDLE;
        end
      endcase
    end
  end

  // memory request, latched while the word is chosen
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mreq_r <= '0;
    end else if (st_r == essl_pkg::S_NEXT) begin
      mreq_r.write <= is_save;
      mreq_r.addr  <= base_r + {21'h0, word, 3'h0};
      mreq_r.be    <= (comp_r == `ESSL_C_PK) ? `ESSL_PK_BE : `ESSL_ALL_BE;
      if (comp_r == `ESSL_C_PK) begin
        mreq_r.wdata <= {32'h0, protection_key_rights_reg_r};
      end else if (comp_r == `ESSL_C_TRACE && idx_r == 8'h00) begin
        mreq_r.wdata <= tctl_r;
      end else if (comp_r == `ESSL_C_TRACE && idx_r >= `ESSL_N_TRACE) begin
        mreq_r.wdata <= `ESSL_RST_64;
      end else begin
        mreq_r.wdata <= st_rdata_i;
      end
    end
  end

  assign mem_valid_o = (st_r == essl_pkg::S_REQ);
  assign mem_req_o   = mreq_r;
  // restored words reach outside registers only after the memory answered
  assign st_we_o     = (st_r == essl_pkg::S_STORE) && !is_save && ext;
  assign st_o        = '{comp: comp_r, idx: idx_r, wdata: rdata_r};

  // trace control word
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tctl_r      <= `ESSL_RST_64;
      tctl_pend_r <= `ESSL_RST_64;
      tctl_pend_v <= 1'b0;
      saved_en_r  <= 1'b0;
      trace_clr_r <= 1'b0;
    end else begin
      if (cmd_go) begin
        tctl_pend_v <= 1'b0;
        trace_clr_r <= 1'b0;
      end else if (wr_acc && idle && avs_address_i == `ESSL_R_TLO) begin
        tctl_r[31:0] <= avs_writedata_i;
      end else if (wr_acc && idle && avs_address_i == `ESSL_R_THI) begin
        tctl_r[63:32] <= avs_writedata_i;
      end
      if (st_r == essl_pkg::S_STORE && comp_r == `ESSL_C_TRACE && idx_r == 8'h00) begin
        if (op_r == essl_pkg::OP_SSAVE) begin
          saved_en_r             <= tctl_r[`ESSL_TRACE_EN];
          trace_clr_r            <= 1'b1;
          tctl_r[`ESSL_TRACE_EN] <= 1'b0;
        end else if (!is_save) begin
          tctl_pend_r <= rdata_r;
          tctl_pend_v <= 1'b1;
        end
      end
      if (st_r == essl_pkg::S_ABORT && op_r == essl_pkg::OP_SSAVE && trace_clr_r) begin
        tctl_r[`ESSL_TRACE_EN] <= saved_en_r;
      end
      if (st_r == essl_pkg::S_FINISH && tctl_pend_v) begin
        tctl_r <= tctl_pend_r;
      end
    end
  end

  // key rights: the loaded value takes over only at the end of the restore
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      protection_key_rights_reg_r      <= `ESSL_RST_32;
      protection_key_rights_reg_pend_r <= `ESSL_RST_32;
      protection_key_rights_reg_pend_v <= 1'b0;
      protection_key_rights_reg_snap_r <= `ESSL_RST_32;
    end else begin
      if (cmd_go) begin
        protection_key_rights_reg_snap_r <= protection_key_rights_reg_r;
        protection_key_rights_reg_pend_v <= 1'b0;
      end else if (wr_acc && idle && avs_address_i == `ESSL_R_PK) begin
        protection_key_rights_reg_r <= avs_writedata_i;
      end
      if (st_r == essl_pkg::S_STORE && comp_r == `ESSL_C_PK && !is_save) begin
        protection_key_rights_reg_pend_r <= rdata_r[31:0];
        protection_key_rights_reg_pend_v <= 1'b1;
      end
      if (st_r == essl_pkg::S_FINISH && protection_key_rights_reg_pend_v) begin
        protection_key_rights_reg_r <= protection_key_rights_reg_pend_r;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_ctl_saved;
    st_r == essl_pkg::S_STORE && op_r == essl_pkg::OP_SSAVE && comp_r == `ESSL_C_TRACE && idx_r == 8'h00;
  endsequence
  sequence s_next_req;
    st_r == essl_pkg::S_NEXT ##1 st_r == essl_pkg::S_REQ;
  endsequence

  a_trace_clear: assert property (s_ctl_saved |=> !tctl_r[`ESSL_TRACE_EN])
    else $error("trace enable not cleared after control word save");
  a_trace_back: assert property (s_ctl_saved ##2 (st_r == essl_pkg::S_REQ && vm_exit_i)
    |=> ##1 tctl_r[`ESSL_TRACE_EN] == saved_en_r)
    else $error("trace enable not returned after aborted save");
  a_gp_trace: assert property ((st_r == essl_pkg::S_CHECK && op_r == essl_pkg::OP_SREST
    && rfbm[`ESSL_TRACE_BIT] && tctl_r[`ESSL_TRACE_EN]) |=> fault_r == essl_pkg::F_GP ##1 idle)
    else $error("restore with trace enabled did not fault");
  a_trace_hold: assert property ((busy_o && !is_save && st_r != essl_pkg::S_FINISH) |=> $stable(tctl_r))
    else $error("trace control changed during restore");
  a_comp_gate: assert property (mem_valid_o |-> rfbm[comp_r] && comp_en[comp_r])
    else $error("access to a disabled component");
  a_trace_gate: assert property (mem_valid_o && comp_r == `ESSL_C_TRACE |-> os_en_r && sce_r[`ESSL_TRACE_BIT]
    && is_sup)
    else $error("trace section touched without supervisor enable");
  a_upper_lim: assert property (s_next_req ##0 (comp_r == `ESSL_C_UPPER && !mode64_r) |-> idx_r < 8'h20)
    else $error("upper half 8-15 touched outside 64-bit mode");
  a_high_skip: assert property (mem_valid_o |-> !(comp_r == `ESSL_C_HIGH && !mode64_r))
    else $error("high bank touched outside 64-bit mode");
  a_resv_zero: assert property (mem_valid_o && comp_r == `ESSL_C_TRACE && idx_r >= 8'h09
    |-> mem_req_o.wdata == 64'h0 && mem_req_o.write)
    else $error("reserved trace word not zero");
  a_pk_lanes: assert property (mem_valid_o && comp_r == `ESSL_C_PK |-> mem_req_o.be == 8'h0F)
    else $error("key rights word uses wrong lanes");
  a_rights_hold: assert property (busy_o && $past(busy_o) |-> $stable(rights_o))
    else $error("access rights changed during operation");
  a_bnd_refuse: assert property (bounds_insn_i && !(os_en_r && uce_r[4:3] == 2'b11) |-> bounds_refuse_o)
    else $error("bounds instruction not refused");
  a_wide_refuse: assert property (wide_insn_i && !(os_en_r && uce_r[7:5] == 3'b111) |-> wide_refuse_o)
    else $error("vector instruction not refused");
endmodule

// ### tb/essl_mem_model.sv
// save-area memory behind the sequencer, with slow answers and error injection
`timescale 1ns/100ps
module essl_mem_model (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  // request side
  input  wire logic                 valid_i,
  input  wire essl_pkg::essl_mem_t  req_i,
  input  wire logic                 slow_i,
  input  wire logic [31:0]          err_addr_i,
  // answer
  output logic                      ack_o,
  output logic                      err_o,
  output logic [63:0]               rdata_o
);
  logic [63:0] mem [0:255];
  logic [2:0]  wait_r;
  initial begin
    ack_o = 1'b0;
    rdata_o = 64'h0;
    for (int i = 0; i < 256; i++) mem[i] = ~64'(i);
  end
  always @(posedge mclk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    // released data must not keep the last word
    rdata_o <= ~rdata_o;
    if (reset_i) wait_r <= 3'h0;
    else if (valid_i && !ack_o) begin
      if (wait_r != 3'h0) wait_r <= wait_r - 3'h1;
      else begin
        ack_o <= 1'b1;
        err_o <= (req_i.addr == err_addr_i);
        rdata_o <= mem[req_i.addr[10:3]];
        wait_r <= slow_i ? req_i.addr[5:3] : 3'h0;
        if (req_i.write && req_i.addr != err_addr_i)
          for (int b = 0; b < 8; b++)
            if (req_i.be[b]) mem[req_i.addr[10:3]][8*b +: 8] <= req_i.wdata[8*b +: 8];
      end
    end
  end
endmodule

// ### tb/essl_core_tb.sv
// self-checking bench for the save/restore sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module essl_core_tb;
  logic                 mclk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]           avs_address_i;
  logic [31:0]          avs_writedata_i, avs_readdata_o, rights_o, err_addr, seed, pk, tlo, thi, rd;
  logic                 mem_valid_o, mem_ack_i, mem_err_i, st_we_o, slow, busy_o;
  logic                 bounds_refuse_o, wide_refuse_o;
  logic                 vm_exit, b_insn, w_insn;
  logic [31:0]          vmx_addr;
  essl_pkg::essl_mem_t  mem_req_o;
  essl_pkg::essl_st_t   st_o;
  logic [63:0]          mem_rdata_i, st [0:4095];
  logic [32:0]          exp_q [$];
  logic [32:0]          note;
  int                   errors, n_compared;

  essl_core i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
    .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i), .mem_rdata_i(mem_rdata_i), .vm_exit_i(vm_exit),
    .st_we_o(st_we_o), .st_o(st_o), .st_rdata_i(st[{st_o.comp, st_o.idx}]), .bounds_insn_i(b_insn),
    .wide_insn_i(w_insn), .bounds_refuse_o(bounds_refuse_o), .wide_refuse_o(wide_refuse_o),
    .rights_o(rights_o), .busy_o(busy_o));
  essl_mem_model i_mem (.mclk_i(mclk_i), .reset_i(reset_i), .valid_i(mem_valid_o), .req_i(mem_req_o),
    .slow_i(slow), .err_addr_i(err_addr), .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i));
  // pipeline exit aimed at one save-area word, raised in the first cycle of its request
  assign vm_exit = mem_valid_o && (mem_req_o.addr == vmx_addr);

  initial mclk_i = 1'b0;
  always #12.5 mclk_i = ~mclk_i;
  // restored state words land in the bench's register file
  always @(posedge mclk_i) if (st_we_o === 1'b1) st[{st_o.comp, st_o.idx}] <= st_o.wdata;
  // completed reads are matched against the oldest note
  always @(negedge mclk_i) if (avs_read_i && avs_waitrequest_o === 1'b0) begin
    note = exp_q.pop_front();
    if (note[32]) `CHK(avs_readdata_o, note[31:0])
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic chk, input logic [31:0] e);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= d;
    if (!wr) exp_q.push_back({chk, e});
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    // let the accepted write settle before the caller looks at outputs
    @(negedge mclk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, 32'h0);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b1, e);
  endtask
  task automatic run(input logic [1:0] op);
    wr(4'h5, {30'h0, op});
    rd = 32'h1;
    for (int k = 0; k < 3000 && rd[0] !== 1'b0; k++) begin
      bus(1'b0, 4'h6, 32'h0, 1'b0, 32'h0);
      if (busy_o === 1'b1) `CHK(rights_o, pk)
    end
    // an operation that never ends counts against the run
    if (rd[0] !== 1'b0) errors++;
  endtask
  // section at word o holds state words 0..n-1 of component c
  task automatic sec(input logic [3:0] c, input int o, input int n);
    for (int k = 0; k < n; k++) `CHK(i_mem.mem[o+k], st[{c, 8'(k)}])
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'd30491;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, slow, pk} = '0;
    {b_insn, w_insn} = 2'b01;
    err_addr = 32'hFFFF_FFFF;
    vmx_addr = 32'hFFFF_FFFF;
    for (int i = 0; i < 4096; i++) st[i] = {rnd(), rnd()};
    reset_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdc(4'hF, 32'h0);
    `CHK(bounds_refuse_o, 1'b0)
    `CHK(wide_refuse_o, 1'b1)
    @(posedge mclk_i);
    b_insn <= 1'b1;
    wr(4'h0, 32'h1);
    wr(4'h1, 32'h0F0);
    `CHK(bounds_refuse_o, 1'b1)
    `CHK(wide_refuse_o, 1'b0)
    // vector save outside 64-bit mode
    wr(4'h3, 32'h0);
    wr(4'h4, 32'h0E0);
    run(2'h0);
    sec(4'h5, 8'h0A, 8);
    sec(4'h6, 8'h12, 32);
    for (int k = 32; k < 192; k++) `CHK(i_mem.mem[8'h12+k], ~64'(8'h12+k))
    // full user save in 64-bit mode, keys disabled
    wr(4'h0, 32'h3);
    wr(4'h1, 32'h0F8);
    `CHK({bounds_refuse_o, wide_refuse_o}, 2'b00)
    wr(4'h4, 32'h3FF);
    slow = 1'b1;
    run(2'h0);
    sec(4'h3, 8'h00, 8);
    sec(4'h4, 8'h08, 2);
    sec(4'h6, 8'h12, 64);
    sec(4'h7, 8'h52, 128);
    `CHK(i_mem.mem[8'hDD], ~64'(8'hDD))
    `CHK(i_mem.mem[8'hD2], ~64'(8'hD2))
    pk = rnd();
    wr(4'h7, pk);
    wr(4'h1, 32'h2F8);
    wr(4'h4, 32'h200);
    run(2'h0);
    `CHK(i_mem.mem[8'hDD], {32'hFFFF_FFFF, pk})
    // supervisor trace save with trace running
    tlo = rnd() | 32'h1;
    thi = rnd();
    wr(4'h8, tlo);
    wr(4'h9, thi);
    wr(4'h2, 32'h100);
    wr(4'h4, 32'h100);
    run(2'h1);
    `CHK(i_mem.mem[8'hD2], {thi, tlo})
    for (int k = 1; k < 9; k++) `CHK(i_mem.mem[8'hD2+k], st[{4'h8, 8'(k)}])
    `CHK({i_mem.mem[8'hDB], i_mem.mem[8'hDC]}, 128'h0)
    rdc(4'h8, tlo & 32'hFFFF_FFFE);
    wr(4'h8, tlo);
    run(2'h3);
    rdc(4'h6, 32'h6);
    err_addr = 32'(8 * 8'hD4);
    run(2'h1);
    rdc(4'h6, 32'hA);
    rdc(4'h8, tlo);
    err_addr = 32'hFFFF_FFFF;
    // exit from the pipeline on the word after the control word
    vmx_addr = 32'(8 * 8'hD3);
    run(2'h1);
    rdc(4'h6, 32'hE);
    rdc(4'h8, tlo);
    vmx_addr = 32'hFFFF_FFFF;
    // supervisor restore with trace stopped loads the whole trace group
    wr(4'h8, tlo & 32'hFFFF_FFFE);
    for (int k = 0; k < 9; k++) i_mem.mem[8'hD2+k] = {rnd(), rnd()};
    run(2'h3);
    for (int k = 1; k < 9; k++) `CHK(st[{4'h8, 8'(k)}], i_mem.mem[8'hD2+k])
    rdc(4'h8, i_mem.mem[8'hD2][31:0]);
    rdc(4'h9, i_mem.mem[8'hD2][63:32]);
    rdc(4'h6, 32'h2);
    // restore bounds and keys from fresh save-area contents
    for (int k = 0; k < 8; k++) i_mem.mem[k] = {rnd(), rnd()};
    i_mem.mem[8'hDD] = {rnd(), rnd()};
    wr(4'h4, 32'h208);
    run(2'h2);
    for (int k = 0; k < 8; k++) `CHK(st[{4'h3, 8'(k)}], i_mem.mem[k])
    pk = i_mem.mem[8'hDD][31:0];
    rdc(4'h7, pk);
    rdc(4'h6, 32'h2);
    report_and_stop();
  end
endmodule
